// ===== psc_partner.sv
// Behavioural far side: measurement front end and blocking matrix line.
`timescale 1ns/100ps
module psc_partner (
	input  wire logic        clock,    // System clock.
	input  wire logic [31:0] meas_set, // Value commanded by the bench.
	input  wire logic        blk_set,  // Blocking commanded by the bench.
	output logic [2:0][31:0] meas_in,  // Measurement channels.
	output logic             block_in  // Blocking matrix line.
);
	// Spare channels sit at zero so disabled comparisons never see stale data.
	always_ff @(posedge clock) begin
		meas_in <= {64'h0, meas_set};
		block_in <= blk_set;
	end
endmodule : psc_partner

// ===== psc_pkg.sv
// Constants, register map and types shared by the programmable stage comparator.
package psc_pkg;

	// Clock and program-cycle timing.
	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned CYCLE_US     = 5000;
	localparam int unsigned CYCLE_CLKS   = CLK_HZ / 1_000_000 * CYCLE_US;
	localparam int unsigned DELTA_MS     = 20;
	localparam int unsigned DELTA_CYCLES = DELTA_MS * 1000 / CYCLE_US;

	// Delay settings are counted in 5 ms program cycles.
	localparam int unsigned DLY_W     = 19;
	localparam int unsigned DLY_MAX_S = 1800;
	localparam logic [18:0] DLY_MAX   = 19'(DLY_MAX_S * 1_000_000 / CYCLE_US);
	localparam int unsigned OP_DLY_MS  = 40;
	localparam int unsigned REL_DLY_MS = 60;
	localparam logic [18:0] OP_DLY_RST  = 19'(OP_DLY_MS * 1000 / CYCLE_US);
	localparam logic [18:0] REL_DLY_RST = 19'(REL_DLY_MS * 1000 / CYCLE_US);

	// Level in units of 0.0001, hysteresis in units of 0.0001 %.
	localparam logic signed [31:0] LEVEL_RST = 32'sh0000_0064;
	localparam logic signed [31:0] BLKLIM_RST = 32'sh0000_0000;
	localparam logic [25:0]        HYST_RST  = 26'h000_7530;
	localparam int unsigned        HYST_ONE  = 1_000_000;
	localparam int unsigned        RATIO_SCALE = 1000;
	localparam int unsigned        REL_SCALE   = 1_000_000;
	localparam int unsigned        NREC        = 12;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_EVSEL   = 8'h04;
	localparam logic [7:0] OFS_OPDLY   = 8'h08;
	localparam logic [7:0] OFS_RELDLY  = 8'h0c;
	localparam logic [7:0] OFS_CMP     = 8'h10;
	localparam logic [7:0] CMP_STRIDE  = 8'h10;
	localparam logic [7:0] OFS_CFG     = 8'h00;
	localparam logic [7:0] OFS_LEVEL   = 8'h04;
	localparam logic [7:0] OFS_HYST    = 8'h08;
	localparam logic [7:0] OFS_BLKLIM  = 8'h0c;
	localparam logic [7:0] OFS_STATUS  = 8'h40;
	localparam logic [7:0] OFS_CNT     = 8'h44;
	localparam logic [7:0] OFS_RATIO   = 8'h50;
	localparam logic [7:0] OFS_RECSEL  = 8'h60;
	localparam logic [7:0] OFS_RECTIME = 8'h64;
	localparam logic [7:0] OFS_RECINFO = 8'h68;
	localparam logic [7:0] OFS_RECMAG  = 8'h6c;
	localparam logic [7:0] OFS_RECRAT  = 8'h70;
	localparam logic [7:0] OFS_RECREM  = 8'h74;
	localparam logic [7:0] OFS_STAMP   = 8'h78;

	// Field positions and reset values.
	localparam int unsigned CTRL_EN_BIT  = 0;
	localparam int unsigned CTRL_GRP_LSB = 1;
	localparam int unsigned CTRL_CLR_BIT = 8;
	localparam int unsigned CFG_EN_BIT   = 3;
	localparam logic [5:0]  EVSEL_RST    = 6'h3f;
	localparam logic [2:0]  GRP_RST      = 3'h0;

	// Event identities held in a record; event vector bit = 2*id + (OFF ? 1 : 0).
	localparam logic [1:0] EV_START = 2'h0;
	localparam logic [1:0] EV_TRIP  = 2'h1;
	localparam logic [1:0] EV_BLOCK = 2'h2;

	typedef enum logic [2:0] {
		MODE_OVER, MODE_OVER_ABS, MODE_UNDER, MODE_UNDER_ABS,
		MODE_DREL_SGN, MODE_DREL_ABS, MODE_DVAL_SGN, MODE_DVAL_ABS
	} psc_mode_e;

	typedef enum logic [2:0] {
		ST_IDLE, ST_START, ST_TRIP, ST_REL_START, ST_REL_TRIP, ST_BLOCKED
	} psc_state_e;

	typedef logic signed [95:0] psc_wide_t;

endpackage : psc_pkg

// ===== psc_stage.sv
// Programmable protection stage: comparators, timing, events, counters and records.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps

module psc_stage
	import psc_pkg::*;
#(
	parameter int unsigned NCMP       = 3,          // Number of comparisons.
	parameter int unsigned CYC_CLKS   = CYCLE_CLKS  // Clocks per program cycle.
) (
	input  wire logic                   clock,      // System clock, 50 MHz.
	input  wire logic                   rstn,       // Synchronous reset, active low.
	input  wire logic                   ce,         // Clock enable, freezes all state.
	input  wire logic [NCMP-1:0][31:0]  meas_in,    // Scaled signed measurements.
	input  wire logic                   block_in,   // Blocking matrix input.
	output logic                        start_out,  // Start output.
	output logic                        trip_out,   // Trip output.
	output logic                        blocked_out,// Blocked output.
	output logic [5:0]                  evt_pulse,  // Selected ON/OFF event pulses.
	output logic [31:0]                 evt_stamp,  // Stamp of the events.
	input  wire logic [7:0]             awaddr,     // AXI write address.
	input  wire logic                   awvalid,    // AXI write address valid.
	output logic                        awready,    // AXI write address ready.
	input  wire logic [31:0]            wdata,      // AXI write data.
	input  wire logic [3:0]             wstrb,      // AXI write strobes.
	input  wire logic                   wvalid,     // AXI write data valid.
	output logic                        wready,     // AXI write data ready.
	output logic [1:0]                  bresp,      // AXI write response.
	output logic                        bvalid,     // AXI write response valid.
	input  wire logic                   bready,     // AXI write response ready.
	input  wire logic [7:0]             araddr,     // AXI read address.
	input  wire logic                   arvalid,    // AXI read address valid.
	output logic                        arready,    // AXI read address ready.
	output logic [31:0]                 rdata,      // AXI read data.
	output logic [1:0]                  rresp,      // AXI read response.
	output logic                        rvalid,     // AXI read data valid.
	input  wire logic                   rready      // AXI read data ready.
);

	logic [7:0]  aw_addr_r;
	logic        aw_held_r, w_held_r;
	logic [31:0] w_data_r, w_mask_r;
	logic [31:0] rdata_nxt;
	logic        rd_hit;
	logic [31:0] cyc_cnt_r, stamp_r;
	logic        tick, tick_d_r;
	logic        blk_m_r, blk_s_r, blk_cyc_r;
	logic        glob_en_r;
	logic [2:0]  grp_r;
	logic [5:0]  evsel_r;
	logic [18:0] op_dly_r, rel_dly_r, op_cnt_r, rel_cnt_r;
	psc_state_e  state_r, state_nxt;
	logic [NCMP-1:0]        act_w;
	logic [NCMP-1:0][31:0]  ratio_w;
	logic [NCMP-1:0][3:0][31:0] cmp_rd_w;
	logic        pu;
	logic        start_prev_r, trip_prev_r, blk_prev_r;
	logic [5:0]  edges;
	logic [15:0] cnt_r [0:2];
	logic [2:0]  cnt_inc;
	logic [31:0] rec_time [0:NREC-1];
	logic [31:0] rec_mag  [0:NREC-1];
	logic [31:0] rec_rat  [0:NREC-1];
	logic [18:0] rec_rem  [0:NREC-1];
	logic [1:0]  rec_id   [0:NREC-1];
	logic [2:0]  rec_grp  [0:NREC-1];
	logic [3:0]  wr_ptr_r, rec_cnt_r, rec_sel_r;
	logic [4:0]  rec_idx;
	logic        rec_go;
	logic [1:0]  rec_new_id;

	// Write path: address and data are taken independently and merged once both are held.
	wire wr_go   = aw_held_r && w_held_r && !bvalid;
	wire rd_go   = arvalid && arready;
	wire clr_cnt = wr_go && aw_addr_r == OFS_CTRL && w_mask_r[CTRL_CLR_BIT] && w_data_r[CTRL_CLR_BIT];
	assign awready = !aw_held_r && !bvalid;
	assign wready  = !w_held_r && !bvalid;
	assign arready = !rvalid;

	// Merge written bytes with the old register value.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
			input logic [31:0] m);
		merge = (old & ~m) | (nv & m);
	endfunction : merge

	// Merged write words: each register keeps the bytes that the strobes leave out.
	wire [31:0] mg_ctrl   = merge({28'h0, grp_r, glob_en_r}, w_data_r, w_mask_r);
	wire [31:0] mg_evsel  = merge({26'h0, evsel_r}, w_data_r, w_mask_r);
	wire [31:0] mg_opdly  = merge({13'h0, op_dly_r}, w_data_r, w_mask_r);
	wire [31:0] mg_reldly = merge({13'h0, rel_dly_r}, w_data_r, w_mask_r);
	wire [31:0] mg_recsel = merge({28'h0, rec_sel_r}, w_data_r, w_mask_r);

	// AXI handshake registers.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			w_mask_r  <= 32'h0000_0000;
			bvalid    <= 1'b0;
			bresp     <= 2'h0;
			rvalid    <= 1'b0;
			rresp     <= 2'h0;
			rdata     <= 32'h0000_0000;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_held_r <= 1'b1;
				w_data_r <= wdata;
				w_mask_r <= {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= (aw_addr_r < OFS_STATUS || aw_addr_r == OFS_RECSEL) ? 2'h0 : 2'h2;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			if (rd_go) begin
				rvalid <= 1'b1;
				rdata  <= rdata_nxt;
				rresp  <= rd_hit ? 2'h0 : 2'h2;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// Program-cycle divider and time stamp; the stamp counts 5 ms cycles.
	assign tick = (cyc_cnt_r == 32'(CYC_CLKS - 1));
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cyc_cnt_r <= 32'h0000_0000;
			stamp_r   <= 32'h0000_0000;
			tick_d_r  <= 1'b0;
		end else if (ce) begin
			cyc_cnt_r <= tick ? 32'h0000_0000 : cyc_cnt_r + 32'h0000_0001;
			stamp_r   <= tick ? stamp_r + 32'h0000_0001 : stamp_r;
			tick_d_r  <= tick;
		end
	end

	// Blocking pin is synchronised, then frozen once per cycle so one cycle sees one value.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			blk_m_r   <= 1'b0;
			blk_s_r   <= 1'b0;
			blk_cyc_r <= 1'b0;
		end else if (ce) begin
			blk_m_r <= block_in;
			blk_s_r <= blk_m_r;
			if (tick) begin
				blk_cyc_r <= blk_s_r;
			end
		end
	end

	// Global settings registers.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			glob_en_r <= 1'b1;
			grp_r     <= GRP_RST;
			evsel_r   <= EVSEL_RST;
			op_dly_r  <= OP_DLY_RST;
			rel_dly_r <= REL_DLY_RST;
			rec_sel_r <= 4'h0;
		end else if (ce && wr_go) begin
			case (aw_addr_r)
				OFS_CTRL: begin
					glob_en_r <= mg_ctrl[CTRL_EN_BIT];
					grp_r     <= mg_ctrl[CTRL_GRP_LSB +: 3];
				end
				OFS_EVSEL:  evsel_r <= mg_evsel[5:0];
				OFS_OPDLY:  op_dly_r <= mg_opdly[18:0];
				OFS_RELDLY: rel_dly_r <= mg_reldly[18:0];
				OFS_RECSEL: rec_sel_r <= mg_recsel[3:0];
				default: ;
			endcase
		end
	end

	// One comparator per measurement channel.
	for (genvar i = 0; i < NCMP; i++) begin : g_cmp
		localparam logic [7:0] BASE = 8'(OFS_CMP + i * CMP_STRIDE);
		psc_mode_e          mode_r;
		logic               en_r, act_r;
		logic signed [31:0] level_r, blklim_r;
		logic [25:0]        hyst_r;
		logic signed [31:0] hist_r [0:DELTA_CYCLES-1];
		logic [31:0]        ratio_r;
		psc_wide_t          m, old, diff, x, t, hh;
		logic               gt, on, off, inhib, act_nxt;
		wire wr_c = wr_go && aw_addr_r == BASE + OFS_CFG;
		wire [31:0] mg_cfg  = merge({28'h0, en_r, mode_r}, w_data_r, w_mask_r);
		wire [31:0] mg_hyst = merge({6'h0, hyst_r}, w_data_r, w_mask_r);

		// Read-back words of this comparison, in register order.
		assign cmp_rd_w[i] = {blklim_r, {6'h0, hyst_r}, level_r, {28'h0, en_r, mode_r}};

		// Pick the quantity and threshold that the mode compares.
		always_comb begin
			m    = psc_wide_t'($signed(meas_in[i]));
			old  = psc_wide_t'(hist_r[DELTA_CYCLES-1]);
			diff = m - old;
			gt   = 1'b1;
			x    = m;
			t    = psc_wide_t'(level_r);
			case (mode_r)
				MODE_OVER:      x = m;
				MODE_OVER_ABS:  x = (m < 0) ? -m : m;
				MODE_UNDER:     gt = 1'b0;
				MODE_UNDER_ABS: begin
					x  = (m < 0) ? -m : m;
					gt = 1'b0;
				end
				MODE_DREL_SGN: begin
					x  = diff * REL_SCALE;
					t  = psc_wide_t'(level_r) * ((old < 0) ? -old : old);
					gt = (level_r >= 0);
				end
				MODE_DREL_ABS: begin
					x = ((diff < 0) ? -diff : diff) * REL_SCALE;
					t = ((level_r < 0) ? -psc_wide_t'(level_r) : psc_wide_t'(level_r))
						* ((old < 0) ? -old : old);
				end
				MODE_DVAL_SGN: begin
					x  = diff;
					gt = (level_r >= 0);
				end
				MODE_DVAL_ABS: begin
					x = (diff < 0) ? -diff : diff;
					t = (level_r < 0) ? -psc_wide_t'(level_r) : psc_wide_t'(level_r);
				end
				default: x = m;
			endcase
		end

		// Hysteresis is a share of the threshold, so it widens the release side only.
		assign hh      = (((t < 0) ? -t : t) * psc_wide_t'(hyst_r)) / HYST_ONE;
		assign on      = gt ? (x > t) : (x < t);
		assign off     = gt ? (x <= t - hh) : (x >= t + hh);
		assign inhib   = (mode_r == MODE_UNDER || mode_r == MODE_UNDER_ABS)
			&& $signed(meas_in[i]) < blklim_r;
		assign act_nxt = en_r && !inhib && (act_r ? !off : on);
		assign act_w[i]   = act_r;
		assign ratio_w[i] = ratio_r;

		// Settings and per-cycle state of this comparison.
		always_ff @(posedge clock) begin
			if (!rstn) begin
				mode_r   <= MODE_OVER;
				en_r     <= (i == 0);
				level_r  <= LEVEL_RST;
				hyst_r   <= HYST_RST;
				blklim_r <= BLKLIM_RST;
				act_r    <= 1'b0;
				ratio_r  <= 32'h0000_0000;
				for (int k = 0; k < DELTA_CYCLES; k++) hist_r[k] <= 32'sh0000_0000;
			end else if (ce) begin
				if (wr_c) begin
					mode_r <= psc_mode_e'(mg_cfg[2:0]);
					en_r   <= mg_cfg[CFG_EN_BIT];
				end
				if (wr_go && aw_addr_r == BASE + OFS_LEVEL) level_r <= merge(level_r, w_data_r, w_mask_r);
				if (wr_go && aw_addr_r == BASE + OFS_HYST) begin
					hyst_r <= mg_hyst[25:0];
				end
				if (wr_go && aw_addr_r == BASE + OFS_BLKLIM) blklim_r <= merge(blklim_r, w_data_r, w_mask_r);
				ratio_r <= (level_r == 0) ? 32'h0000_0000 :
					32'((m * psc_wide_t'(RATIO_SCALE)) / psc_wide_t'(level_r));
				if (tick) begin
					act_r     <= act_nxt;
					hist_r[0] <= meas_in[i];
					for (int k = 1; k < DELTA_CYCLES; k++) hist_r[k] <= hist_r[k-1];
				end
			end
		end

		property p_under_blk;
			@(posedge clock) disable iff (!rstn)
			ce && tick && inhib |=> !act_r;
		endproperty
		a_under_blk: assert property (p_under_blk) else $error("under blocking limit ignored");
	end

	assign pu = glob_en_r && (|act_w);

	// Stage sequencer, stepped one clock after the comparators update.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (pu) state_nxt = blk_cyc_r ? ST_BLOCKED : ST_START;
			ST_START: begin
				if (!pu || blk_cyc_r) state_nxt = ST_REL_START;
				else if (op_cnt_r + 19'h1 >= op_dly_r) state_nxt = ST_TRIP;
			end
			ST_REL_START: begin
				if (pu && !blk_cyc_r) state_nxt = ST_START;
				else if (rel_cnt_r + 19'h1 >= rel_dly_r) state_nxt = blk_cyc_r && pu ? ST_BLOCKED
					: ST_IDLE;
			end
			ST_TRIP: if (!pu) state_nxt = ST_REL_TRIP;
			ST_REL_TRIP: begin
				if (pu) state_nxt = ST_TRIP;
				else if (rel_cnt_r + 19'h1 >= rel_dly_r) state_nxt = ST_IDLE;
			end
			ST_BLOCKED: if (!pu) state_nxt = ST_IDLE; else if (!blk_cyc_r) state_nxt = ST_START;
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Timers keep the operating count through a release so a short dip does not restart it.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_r     <= ST_IDLE;
			op_cnt_r    <= 19'h0;
			rel_cnt_r   <= 19'h0;
			start_out   <= 1'b0;
			trip_out    <= 1'b0;
			blocked_out <= 1'b0;
		end else if (ce && tick_d_r) begin
			state_r     <= state_nxt;
			op_cnt_r    <= (state_nxt == ST_START && state_r != ST_IDLE && state_r != ST_BLOCKED)
				? op_cnt_r + 19'h1 : (state_nxt == ST_START ? 19'h0 : op_cnt_r);
			rel_cnt_r   <= (state_nxt == state_r) ? rel_cnt_r + 19'h1 : 19'h0;
			start_out   <= (state_nxt == ST_START);
			trip_out    <= (state_nxt == ST_TRIP || state_nxt == ST_REL_TRIP);
			blocked_out <= (state_nxt == ST_BLOCKED);
		end
	end

	// Event edges: even bits are ON, odd bits OFF, in the order start, trip, blocked.
	assign edges = {!blocked_out && blk_prev_r, blocked_out && !blk_prev_r,
		!trip_out && trip_prev_r, trip_out && !trip_prev_r,
		!start_out && start_prev_r, start_out && !start_prev_r};
	assign cnt_inc    = {edges[4], edges[2], edges[0]};
	assign rec_go     = |cnt_inc;
	assign rec_new_id = edges[2] ? EV_TRIP : (edges[4] ? EV_BLOCK : EV_START);
	always_ff @(posedge clock) begin
		if (!rstn) begin
			start_prev_r <= 1'b0;
			trip_prev_r  <= 1'b0;
			blk_prev_r   <= 1'b0;
			evt_pulse    <= 6'h00;
			evt_stamp    <= 32'h0000_0000;
		end else if (ce) begin
			start_prev_r <= start_out;
			trip_prev_r  <= trip_out;
			blk_prev_r   <= blocked_out;
			evt_pulse    <= edges & evsel_r;
			if (|edges) evt_stamp <= stamp_r;
		end
	end

	// Counters; a count in the clearing cycle survives as one.
	for (genvar j = 0; j < 3; j++) begin : g_cnt
		always_ff @(posedge clock) begin
			if (!rstn) begin
				cnt_r[j] <= 16'h0000;
			end else if (ce) begin
				if (clr_cnt) cnt_r[j] <= {15'h0, cnt_inc[j]};
				else if (cnt_inc[j]) cnt_r[j] <= cnt_r[j] + 16'h0001;
			end
		end
	end

	// Record ring, newest overwriting the oldest.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			wr_ptr_r  <= 4'h0;
			rec_cnt_r <= 4'h0;
		end else if (ce && rec_go) begin
			rec_time[wr_ptr_r] <= stamp_r;
			rec_id[wr_ptr_r]   <= rec_new_id;
			rec_mag[wr_ptr_r]  <= meas_in[0];
			rec_rat[wr_ptr_r]  <= ratio_w[0];
			rec_rem[wr_ptr_r]  <= (state_r == ST_START) ? op_dly_r - op_cnt_r : 19'h0;
			rec_grp[wr_ptr_r]  <= grp_r;
			wr_ptr_r  <= (wr_ptr_r == 4'(NREC - 1)) ? 4'h0 : wr_ptr_r + 4'h1;
			rec_cnt_r <= (rec_cnt_r == 4'(NREC)) ? rec_cnt_r : rec_cnt_r + 4'h1;
		end
	end

	// Read selection; index 0 is the newest record.
	wire [4:0] rec_raw = 5'(NREC) + {1'b0, wr_ptr_r} - 5'h1 - {1'b0, rec_sel_r};
	assign rec_idx = (rec_raw >= 5'(NREC)) ? rec_raw - 5'(NREC) : rec_raw;
	wire [3:0] ri  = rec_idx[3:0];
	always_comb begin
		rd_hit    = 1'b1;
		rdata_nxt = 32'h0000_0000;
		case (araddr)
			OFS_CTRL:    rdata_nxt = {28'h0, grp_r, glob_en_r};
			OFS_EVSEL:   rdata_nxt = {26'h0, evsel_r};
			OFS_OPDLY:   rdata_nxt = {13'h0, op_dly_r};
			OFS_RELDLY:  rdata_nxt = {13'h0, rel_dly_r};
			OFS_STATUS:  rdata_nxt = {20'h0, act_w, pu, blk_cyc_r, blocked_out, trip_out,
				start_out, 1'b0, state_r};
			OFS_CNT:     rdata_nxt = {16'h0, cnt_r[0]};
			OFS_CNT + 8'h04: rdata_nxt = {16'h0, cnt_r[1]};
			OFS_CNT + 8'h08: rdata_nxt = {16'h0, cnt_r[2]};
			OFS_RECSEL:  rdata_nxt = {28'h0, rec_sel_r};
			OFS_RECTIME: rdata_nxt = rec_time[ri];
			OFS_RECINFO: rdata_nxt = {20'h0, rec_cnt_r, 3'h0, rec_grp[ri], rec_id[ri]};
			OFS_RECMAG:  rdata_nxt = rec_mag[ri];
			OFS_RECRAT:  rdata_nxt = rec_rat[ri];
			OFS_RECREM:  rdata_nxt = {13'h0, rec_rem[ri]};
			OFS_STAMP:   rdata_nxt = stamp_r;
			default: begin
				rd_hit = 1'b0;
				for (int k = 0; k < NCMP; k++) begin
					if (araddr == 8'(OFS_RATIO + 4 * k)) begin
						rd_hit    = 1'b1;
						rdata_nxt = ratio_w[k];
					end
					for (int r = 0; r < 4; r++) begin
						if (araddr == 8'(OFS_CMP + CMP_STRIDE * k + 4 * r)) begin
							rd_hit    = 1'b1;
							rdata_nxt = cmp_rd_w[k][r];
						end
					end
				end
			end
		endcase
	end

	sequence s_step;
		ce && tick_d_r;
	endsequence
	sequence s_rd_req;
		ce && rd_go;
	endsequence

	property p_start_go;
		@(posedge clock) disable iff (!rstn)
		s_step ##0 (state_r == ST_IDLE && pu && !blk_cyc_r) |=> start_out && !blocked_out;
	endproperty
	a_start_go: assert property (p_start_go) else $error("start not raised");

	property p_blk_go;
		@(posedge clock) disable iff (!rstn)
		s_step ##0 (state_r == ST_IDLE && pu && blk_cyc_r) |=> blocked_out && !start_out;
	endproperty
	a_blk_go: assert property (p_blk_go) else $error("blocked not raised");

	property p_late_blk;
		@(posedge clock) disable iff (!rstn)
		s_step ##0 (state_r == ST_START && blk_cyc_r) |=> !start_out && state_r == ST_REL_START;
	endproperty
	a_late_blk: assert property (p_late_blk) else $error("start kept under blocking");

	property p_trip;
		@(posedge clock) disable iff (!rstn)
		s_step ##0 (state_r == ST_START && pu && !blk_cyc_r && op_cnt_r + 19'h1 >= op_dly_r)
		|=> trip_out;
	endproperty
	a_trip: assert property (p_trip) else $error("trip missing after delay");

	property p_blk_hold;
		@(posedge clock) disable iff (!rstn)
		ce && !tick |=> $stable(blk_cyc_r);
	endproperty
	a_blk_hold: assert property (p_blk_hold) else $error("blocking changed mid cycle");

	property p_clr;
		@(posedge clock) disable iff (!rstn)
		ce && clr_cnt && !cnt_inc[1] |=> cnt_r[1] == 16'h0000;
	endproperty
	a_clr: assert property (p_clr) else $error("trip counter not cleared");

	property p_evt;
		@(posedge clock) disable iff (!rstn)
		ce && edges[2] |=> evt_pulse[2] == $past(evsel_r[2]) && evt_stamp == $past(stamp_r);
	endproperty
	a_evt: assert property (p_evt) else $error("trip ON event wrong");

	property p_rec;
		@(posedge clock) disable iff (!rstn)
		ce && rec_go |=> wr_ptr_r == (($past(wr_ptr_r) == 4'hb) ? 4'h0 : $past(wr_ptr_r) + 4'h1);
	endproperty
	a_rec: assert property (p_rec) else $error("record pointer wrong");

	property p_rd;
		@(posedge clock) disable iff (!rstn)
		s_rd_req |=> rvalid && !arready;
	endproperty
	a_rd: assert property (p_rd) else $error("read answer missing");

endmodule : psc_stage

// ===== psc_stage_test.sv
// Self-checking bench for the stage: bus access, comparator modes and blocking.
`timescale 1ns/100ps
module psc_stage_test;
	import psc_pkg::*;
	logic clock = 0, rstn = 0, ce = 1, blk_set = 0, bready = 0, rready = 0;
	logic awvalid = 0, wvalid = 0, arvalid = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, meas_set = 0, rdata;
	logic [3:0] wstrb = 0;
	logic [2:0][31:0] meas_in;
	logic [1:0] bresp, rresp;
	logic block_in, start_out, trip_out, blocked_out, awready, wready, bvalid, arready, rvalid;
	int error_cnt = 0, tests_run = 0;
	wire [2:0] outs = {blocked_out, trip_out, start_out};
	logic [5:0] evt_pulse, ev_seen = 0;
	logic [31:0] evt_stamp;
	// Every event pulse seen since reset, so one-cycle pulses are not missed.
	always @(posedge clock) if (rstn) ev_seen <= ev_seen | evt_pulse;
	psc_stage #(.CYC_CLKS(20)) i_psc_stage (.clock, .rstn, .ce, .meas_in, .block_in,
		.start_out, .trip_out, .blocked_out, .evt_pulse, .evt_stamp, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	psc_partner i_psc_partner (.clock, .meas_set, .blk_set, .meas_in, .block_in);
	initial begin
		forever #10 clock = ~clock;
	end
	task chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Both channels stay offered until each is taken, then the response is awaited.
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ad, wd;
		ad = 0;
		wd = 0;
		awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
		do begin
			@(posedge clock);
			if (!ad && awready) begin ad = 1; awvalid <= 0; end
			if (!wd && wready) begin wd = 1; wvalid <= 0; end
		end while (!bvalid);
		bready <= 0;
		@(posedge clock);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a; arvalid <= 1; rready <= 1;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		chk("rd", {rresp, rdata}, {er, e});
		rready <= 0;
		@(posedge clock);
	endtask : rd
	// Bounded wait for an output level; the bound covers delays of a few program cycles.
	task wout(input int b, input logic v);
		for (int n = 0; n < 400 && outs[b] !== v; n++) @(posedge clock);
		chk("out", outs[b], v);
	endtask : wout
	task meas(input logic [31:0] m, input logic bk);
		meas_set <= m;
		blk_set <= bk;
		@(posedge clock);
	endtask : meas
	task complete_run;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	initial begin
		#400_000;
		error_cnt++;
		complete_run();
	end
	initial begin
		repeat (10) @(posedge clock);
		rstn <= 1;
		@(posedge clock);
		rd(OFS_OPDLY, 32'h8, 2'h0);
		rd(OFS_RELDLY, 32'hc, 2'h0);
		rd(OFS_CMP + OFS_LEVEL, 32'h64, 2'h0);
		rd(OFS_CMP + OFS_HYST, 32'h7530, 2'h0);
		rd(8'hfc, 32'h0, 2'h2);
		wr(OFS_OPDLY, 32'h2);
		wr(OFS_RELDLY, 32'h1);
		meas(32'd200, 0);
		wout(0, 1);
		wout(1, 1);
		rd(OFS_RATIO, 32'h7d0, 2'h0);
		meas(32'd0, 0);
		wout(1, 0);
		wout(0, 0);
		rd(OFS_CNT, 32'h1, 2'h0);
		rd(OFS_CNT + 8'h4, 32'h1, 2'h0);
		rd(OFS_RECINFO, 32'h201, 2'h0);
		wr(OFS_RECSEL, 32'h1);
		rd(OFS_RECREM, 32'h2, 2'h0);
		chk("events", ev_seen, 6'h0f);
		chk("stamp", evt_stamp != 32'h0, 1'b1);
		wr(OFS_CTRL, 32'h101);
		rd(OFS_CNT, 32'h0, 2'h0);
		meas(32'd0, 1);
		repeat (3) @(posedge clock);
		meas(32'd200, 1);
		wout(2, 1);
		chk("start", start_out, 1'b0);
		meas(32'd0, 0);
		wout(2, 0);
		meas(32'd200, 0);
		wout(0, 1);
		meas(32'd200, 1);
		wout(0, 0);
		meas(32'd0, 0);
		wout(2, 0);
		wout(1, 0);
		wr(OFS_CMP, 32'h9);
		meas(-32'sd200, 0);
		wout(0, 1);
		rd(OFS_RATIO, 32'hffff_f830, 2'h0);
		meas(32'd0, 0);
		wout(0, 0);
		wr(OFS_CMP + OFS_BLKLIM, 32'd50);
		wr(OFS_CMP, 32'ha);
		meas(32'd20, 0);
		repeat (100) @(posedge clock);
		chk("start", start_out, 1'b0);
		meas(32'd70, 0);
		wout(0, 1);
		meas(32'd200, 0);
		wout(0, 0);
		meas(32'd0, 0);
		repeat (100) @(posedge clock);
		wr(OFS_CMP, 32'hf);
		meas(32'd500, 0);
		wout(0, 1);
		chk("events", ev_seen, 6'h3f);
		complete_run();
	end
endmodule : psc_stage_test
